// *** rtl/pcc_top.v ***
// clock configuration: trim, pll control, output divider, aux clock select
//
// Overview of operation
// RULE1: aux clock is crystal times feedback value, halved, then out-divided.
// RULE2: feedback field decode: 00->23, 01->27, 10->28, 11->23.
// RULE3: feedback selection sits in control bits 1 and 0.
// RULE4: output divider divides by its value 8..254; 0..7 reserved.
// RULE5: select 0 frees pin for gpio, 2 holds low, 3 holds high.
// RULE6: select 1 drives pll output; select field is control bits 7..4.
// RULE7: selects 4..7 give crystal divided by one, two, four, eight.
// RULE8: selects 8..B toggle the pin on timer 0..3 overflow.
// RULE9: selected clock reaches pin only while enable bit 3 is set.
// RULE10: full 8-bit trim drives oscillator; larger value means slower.
// RULE11: power-down bit 2 stops pll; pll selections carry no clock.
//
// The plain strobed port was left to the implementer.
`default_nettype none
`include "pcc_defines.vh"
module pcc_top
(
  input  wire       i_sys_clk,
  input  wire       i_rst,
  // register port
  input  wire [7:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output wire [7:0] o_rdata,
  // crystal derived tick and pll tick, both from outside the clock domain
  input  wire       i_xtal_clk,
  input  wire       i_pll_tick,
  // timer overflow pulses, same domain
  input  wire [3:0] i_timer_ovf,
  // general purpose output driven while pin is freed
  input  wire       i_gpio_out,
  input  wire       i_gpio_oe,
  // aux clock pin
  input  wire       i_aux_clock_pin,
  output wire       o_aux_clock_pin,
  output wire       o_aux_clock_pin_oe,
  output wire       o_aux_clock_pin_in,
  // analog controls
  output wire [7:0] o_low_freq_osc_trim,
  output wire [5:0] o_pll_feedback_divider,
  output wire       o_pll_power_down
);

  // ==========================================================
  // functions
  // ==========================================================
  function [5:0] fb_decode;
    input [1:0] code;
    begin
      case (code)
        2'b01:   fb_decode = `PCC_FB_DIV_B;
        2'b10:   fb_decode = `PCC_FB_DIV_C;
        default: fb_decode = `PCC_FB_DIV_A;
      endcase
    end
  endfunction

  function is_addr;
    input [7:0] a;
    input [7:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  // ==========================================================
  // registers
  // ==========================================================
  reg  [7:0] low_freq_osc_trim_r;
  reg  [7:0] pll_control_r;
  reg  [7:0] pll_output_divider_r;
  reg  [7:0] rdata_r;
  reg  [7:0] rdata_nxt;
  reg  [7:0] low_freq_osc_trim_nxt;
  reg  [7:0] pll_control_nxt;
  reg  [7:0] pll_output_divider_nxt;

  // unmapped writes fall through and leave every register as it was
  always @*
  begin
    low_freq_osc_trim_nxt  = low_freq_osc_trim_r;
    pll_control_nxt        = pll_control_r;
    pll_output_divider_nxt = pll_output_divider_r;
    if (i_wr)
    begin
      if (is_addr(i_addr, `PCC_ADDR_OSC_TRIM))
        low_freq_osc_trim_nxt = i_wdata; // RULE10
      if (is_addr(i_addr, `PCC_ADDR_PLL_CONTROL))
        pll_control_nxt = i_wdata; // RULE3
      if (is_addr(i_addr, `PCC_ADDR_PLL_OUT_DIV))
        pll_output_divider_nxt = i_wdata; // RULE4
    end
  end

  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      low_freq_osc_trim_r  <= `PCC_RST_OSC_TRIM;
      pll_control_r        <= `PCC_RST_PLL_CONTROL;
      pll_output_divider_r <= `PCC_RST_PLL_OUT_DIV;
    end
    else
    begin
      low_freq_osc_trim_r  <= low_freq_osc_trim_nxt;
      pll_control_r        <= pll_control_nxt;
      pll_output_divider_r <= pll_output_divider_nxt;
    end
  end

  // ==========================================================
  // control fields
  // ==========================================================
  wire [1:0] fb_code;
  wire       pll_power_down;
  wire       aux_clock_output_enable;
  wire [3:0] aux_clock_source_select;

  assign fb_code = pll_control_r[`PCC_FB_MSB:`PCC_FB_LSB]; // RULE3
  assign pll_power_down = pll_control_r[`PCC_PD_BIT];
  assign aux_clock_output_enable = pll_control_r[`PCC_OE_BIT]; // RULE9
  assign aux_clock_source_select =
    pll_control_r[`PCC_SEL_MSB:`PCC_SEL_LSB]; // RULE6

  // ==========================================================
  // input synchronisers
  // ==========================================================
  wire xtal_s;
  wire pll_s;
  wire pin_s;

  pcc_sync2 u_sync_xtal
  (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_d       (i_xtal_clk),
    .o_q       (xtal_s)
  );

  pcc_sync2 u_sync_pll
  (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_d       (i_pll_tick),
    .o_q       (pll_s)
  );

  pcc_sync2 u_sync_pin
  (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_d       (i_aux_clock_pin),
    .o_q       (pin_s)
  );

  // ==========================================================
  // crystal and pll edge detection
  // ==========================================================
  // the crystal outruns this clock, so the synchronised level is a
  // sampled image; ratios are exact in ticks, not in real frequency
  reg xtal_d_r;
  reg pll_d_r;
  wire xtal_rise;
  wire pll_rise;

  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      xtal_d_r <= 1'b0;
      pll_d_r  <= 1'b0;
    end
    else
    begin
      xtal_d_r <= xtal_s;
      pll_d_r  <= pll_s;
    end
  end

  assign xtal_rise = xtal_s & ~xtal_d_r;
  assign pll_rise  = pll_s & ~pll_d_r;

  // crystal division chain: /2, /4, /8
  reg  [2:0] xdiv_r;
  wire [2:0] xdiv_nxt;

  // one count per crystal rise, so bit k runs at the crystal over 2^(k+1)
  assign xdiv_nxt = xtal_rise ? xdiv_r + 3'h1 : xdiv_r; // RULE7

  always @(posedge i_sys_clk)
  begin
    if (i_rst)
      xdiv_r <= 3'h0;
    else
      xdiv_r <= xdiv_nxt;
  end

  // ==========================================================
  // pll output divider stage
  // ==========================================================
  // the vco itself is analog: fed by the crystal, multiplied by the
  // decoded feedback value and halved; i_pll_tick is its result
  wire       div_run;
  wire       pll_div_clk;

  // reserved divider values stop the stage instead of misdividing
  assign div_run = ~pll_power_down &
                   (pll_output_divider_r >= `PCC_OUT_DIV_MIN); // RULE4 RULE11

  pcc_div u_out_div
  (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_run     (div_run),
    .i_tick    (pll_rise),
    .i_div     (pll_output_divider_r),
    .o_clk     (pll_div_clk)
  ); // RULE1

  // ==========================================================
  // timer toggle
  // ==========================================================
  reg  tmr_tgl_r;
  wire tmr_sel;
  wire tmr_hit;

  // only the selected timer counts; the others may overflow freely
  assign tmr_sel = (aux_clock_source_select[3:2] == 2'b10);
  assign tmr_hit = tmr_sel & i_timer_ovf[aux_clock_source_select[1:0]];

  always @(posedge i_sys_clk)
  begin
    if (i_rst)
      tmr_tgl_r <= 1'b0;
    else if (tmr_hit)
      tmr_tgl_r <= ~tmr_tgl_r; // RULE8
  end

  // ==========================================================
  // output selector
  // ==========================================================
  reg aux_out_nxt;
  reg aux_oe_nxt;
  reg aux_out_r;
  reg aux_oe_r;
  reg pin_in_r;
  reg [7:0] trim_out_r;
  reg [5:0] fb_out_r;
  reg pd_out_r;

  always @*
  begin
    aux_out_nxt = 1'b0;
    aux_oe_nxt  = aux_clock_output_enable; // RULE9
    case (aux_clock_source_select)
      `PCC_SEL_GPIO:
      begin
        aux_out_nxt = i_gpio_out;
        aux_oe_nxt  = i_gpio_oe; // RULE5
      end
      `PCC_SEL_PLL:   aux_out_nxt = pll_div_clk; // RULE6 RULE11
      `PCC_SEL_LOW:   aux_out_nxt = 1'b0; // RULE5
      `PCC_SEL_HIGH:  aux_out_nxt = 1'b1; // RULE5
      `PCC_SEL_XTAL1: aux_out_nxt = xtal_s; // RULE7
      `PCC_SEL_XTAL2: aux_out_nxt = xdiv_r[0]; // RULE7
      `PCC_SEL_XTAL4: aux_out_nxt = xdiv_r[1]; // RULE7
      `PCC_SEL_XTAL8: aux_out_nxt = xdiv_r[2]; // RULE7
      `PCC_SEL_TMR0,
      `PCC_SEL_TMR1,
      `PCC_SEL_TMR2,
      `PCC_SEL_TMR3:  aux_out_nxt = tmr_tgl_r; // RULE8
      default:
      begin
        // reserved codes leave the pin undriven
        aux_out_nxt = 1'b0;
        aux_oe_nxt  = 1'b0;
      end
    endcase
  end

  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      aux_out_r  <= 1'b0;
      aux_oe_r   <= 1'b0;
      pin_in_r   <= 1'b0;
      trim_out_r <= `PCC_RST_OSC_TRIM;
      fb_out_r   <= `PCC_FB_DIV_A;
      pd_out_r   <= 1'b0;
    end
    else
    begin
      aux_out_r  <= aux_out_nxt;
      aux_oe_r   <= aux_oe_nxt;
      pin_in_r   <= pin_s;
      trim_out_r <= low_freq_osc_trim_r; // RULE10
      fb_out_r   <= fb_decode(fb_code); // RULE2
      pd_out_r   <= pll_power_down; // RULE11
    end
  end

  // ==========================================================
  // read port
  // ==========================================================
  // status: bit 3 divider running, bit 2 timer toggle, bit 1 divided
  // pll clock, bit 0 synchronised pin level; upper bits read zero
  wire [7:0] status_word;
  assign status_word = {4'h0, div_run, tmr_tgl_r, pll_div_clk, pin_in_r};

  always @*
  begin
    rdata_nxt = 8'h00;
    if (i_rd)
    begin
      if (is_addr(i_addr, `PCC_ADDR_OSC_TRIM))
        rdata_nxt = low_freq_osc_trim_r;
      else if (is_addr(i_addr, `PCC_ADDR_PLL_CONTROL))
        rdata_nxt = pll_control_r;
      else if (is_addr(i_addr, `PCC_ADDR_PLL_OUT_DIV))
        rdata_nxt = pll_output_divider_r;
      else if (is_addr(i_addr, `PCC_ADDR_STATUS))
        rdata_nxt = status_word;
    end
  end

  always @(posedge i_sys_clk)
  begin
    if (i_rst)
      rdata_r <= 8'h00;
    else
      rdata_r <= rdata_nxt;
  end

  assign o_rdata                = rdata_r;
  assign o_aux_clock_pin        = aux_out_r;
  assign o_aux_clock_pin_oe     = aux_oe_r;
  assign o_aux_clock_pin_in     = pin_in_r;
  assign o_low_freq_osc_trim    = trim_out_r;
  assign o_pll_feedback_divider = fb_out_r;
  assign o_pll_power_down       = pd_out_r;
endmodule
`default_nettype wire

// *** rtl/pcc_defines.vh ***
// register map, field positions and reset values of the clock config block
`ifndef PCC_DEFINES_VH
`define PCC_DEFINES_VH

// register offsets
`define PCC_ADDR_OSC_TRIM     8'h3C
`define PCC_ADDR_PLL_CONTROL  8'h3D
`define PCC_ADDR_PLL_OUT_DIV  8'h3E
`define PCC_ADDR_STATUS       8'h3F

// control register fields
`define PCC_FB_LSB            0
`define PCC_FB_MSB            1
`define PCC_PD_BIT            2
`define PCC_OE_BIT            3
`define PCC_SEL_LSB           4
`define PCC_SEL_MSB           7

// reset values
`define PCC_RST_OSC_TRIM      8'h80
`define PCC_RST_PLL_CONTROL   8'h00
`define PCC_RST_PLL_OUT_DIV   8'h08

// feedback divider decode values
`define PCC_FB_DIV_A          6'h17
`define PCC_FB_DIV_B          6'h1B
`define PCC_FB_DIV_C          6'h1C

// smallest legal output divider
`define PCC_OUT_DIV_MIN       8'h08

// source select codes
`define PCC_SEL_GPIO          4'h0
`define PCC_SEL_PLL           4'h1
`define PCC_SEL_LOW           4'h2
`define PCC_SEL_HIGH          4'h3
`define PCC_SEL_XTAL1         4'h4
`define PCC_SEL_XTAL2         4'h5
`define PCC_SEL_XTAL4         4'h6
`define PCC_SEL_XTAL8         4'h7
`define PCC_SEL_TMR0          4'h8
`define PCC_SEL_TMR1          4'h9
`define PCC_SEL_TMR2          4'hA
`define PCC_SEL_TMR3          4'hB

`endif

// *** rtl/pcc_sync2.v ***
// two flip-flop synchroniser for one level
`default_nettype none
module pcc_sync2
(
  input  wire i_sys_clk,
  input  wire i_rst,
  input  wire i_d,
  output wire o_q
);
  reg meta_r;
  reg q_r;

  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      meta_r <= 1'b0;
      q_r    <= 1'b0;
    end
    else
    begin
      meta_r <= i_d;
      q_r    <= meta_r;
    end
  end

  assign o_q = q_r;
endmodule
`default_nettype wire

// *** rtl/pcc_div.v ***
// programmable divider: toggles its output to divide the tick rate by n
`default_nettype none
module pcc_div
(
  input  wire       i_sys_clk,
  input  wire       i_rst,
  input  wire       i_run,
  input  wire       i_tick,
  input  wire [7:0] i_div,
  output wire       o_clk
);
  reg [7:0] cnt_r;
  reg       clk_r;
  wire [7:0] half_lo;
  wire [7:0] half_hi;

  // odd ratios: low half one tick longer than high half
  assign half_hi = {1'b0, i_div[7:1]};
  assign half_lo = i_div - half_hi;

  always @(posedge i_sys_clk)
  begin
    if (i_rst || !i_run)
    begin
      cnt_r <= 8'h00;
      clk_r <= 1'b0;
    end
    else if (i_tick)
    begin
      if (cnt_r + 8'h01 >= (clk_r ? half_hi : half_lo))
      begin
        cnt_r <= 8'h00;
        clk_r <= ~clk_r;
      end
      else
      begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end

  assign o_clk = clk_r;
endmodule
`default_nettype wire

// *** testbench/pcc_top_sva.sv ***
// assertions for the clock configuration block
`default_nettype none
module pcc_top_sva
(
  input wire logic       i_sys_clk,
  input wire logic       i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic [3:0] i_timer_ovf,
  input wire logic       o_aux_clock_pin,
  input wire logic       o_aux_clock_pin_oe,
  input wire logic [7:0] o_low_freq_osc_trim,
  input wire logic [5:0] o_pll_feedback_divider,
  input wire logic       o_pll_power_down
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====
  // shadow registers
  logic [7:0] ctrl_r;
  logic [7:0] trim_r;
  logic [3:0] sel;
  logic       tmr_en;
  assign sel = ctrl_r[7:4];
  assign tmr_en = sel[3:2] == 2'b10 && ctrl_r[3];
  always_ff @(posedge i_sys_clk)
    if (i_rst)
    begin
      ctrl_r <= 8'h00;
      trim_r <= 8'h80;
    end
    else if (i_wr && i_addr == 8'h3D)
      ctrl_r <= i_wdata;
    else if (i_wr && i_addr == 8'h3C)
      trim_r <= i_wdata;
  function automatic logic [5:0] fb(input logic [1:0] c);
    return (c == 2'h1) ? 6'h1B : (c == 2'h2) ? 6'h1C : 6'h17;
  endfunction
  // ====
  // properties
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // selection must hold still, or the pin source itself moves
  sequence s_hit;
    tmr_en && i_timer_ovf[sel[1:0]] ##1 tmr_en && $stable(sel);
  endsequence
  sequence s_idle;
    tmr_en && !i_timer_ovf[sel[1:0]] ##1 tmr_en && $stable(sel);
  endsequence
  a_rd_idle: assert property (
    !$past(i_rd) |-> o_rdata == 8'h00) else $error("rdata not idle");
  a_ctrl_read: assert property (
    $past(i_rd) && $past(i_addr) == 8'h3D |-> o_rdata == ctrl_r)
    else $error("control readback");
  a_fb_decode: assert property (
    o_pll_feedback_divider == fb($past(ctrl_r[1:0]))) else $error("fb");
  a_pd_copy: assert property (
    o_pll_power_down == $past(ctrl_r[2])) else $error("power down");
  a_trim_copy: assert property (
    o_low_freq_osc_trim == $past(trim_r)) else $error("trim");
  a_oe_gate: assert property (
    $past(sel) inside {[1:11]} |-> o_aux_clock_pin_oe == $past(ctrl_r[3]))
    else $error("enable gate");
  a_rfu_off: assert property (
    $past(sel) >= 4'hC |-> !o_aux_clock_pin_oe) else $error("reserved oe");
  a_fixed_lvl: assert property (
    $past(sel[3:1]) == 3'b001 && $past(ctrl_r[3])
    |-> o_aux_clock_pin == $past(sel[0])) else $error("fixed level");
  a_tmr_toggle: assert property (
    s_hit |=> o_aux_clock_pin != $past(o_aux_clock_pin))
    else $error("no toggle");
  a_tmr_hold: assert property (
    s_idle |=> $stable(o_aux_clock_pin)) else $error("stray toggle");
endmodule
bind pcc_top pcc_top_sva i_sva (.i_sys_clk, .i_rst, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .i_timer_ovf, .o_aux_clock_pin,
  .o_aux_clock_pin_oe, .o_low_freq_osc_trim, .o_pll_feedback_divider,
  .o_pll_power_down);
`default_nettype wire

// *** testbench/pcc_top_tb.sv ***
// self-checking bench for the clock configuration block
`default_nettype none
module pcc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       i_sys_clk = 0;
  logic       i_rst = 1;
  logic       i_wr = 0, i_rd = 0, i_gpio_out = 0, i_gpio_oe = 0;
  logic [7:0] i_addr = 0, i_wdata = 0, ph = 0, v, r;
  logic [3:0] i_timer_ovf = 0;
  logic [7:0] o_rdata, o_low_freq_osc_trim;
  logic [5:0] o_pll_feedback_divider;
  logic       o_aux_clock_pin, o_aux_clock_pin_oe, o_aux_clock_pin_in;
  logic       o_pll_power_down, p;
  int         mismatches = 0, n_tests = 0, seed = 32'heaa5072a, n;
  always #25 i_sys_clk = ~i_sys_clk;
  // crystal and pll ticks at a quarter of the system rate
  always @(posedge i_sys_clk)
    ph <= ph + 8'h01;
  pcc_top i_dut (.i_sys_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_xtal_clk(ph[1]), .i_pll_tick(ph[1]), .i_timer_ovf,
    .i_gpio_out, .i_gpio_oe, .i_aux_clock_pin(ph[3] ^ ph[0]),
    .o_aux_clock_pin, .o_aux_clock_pin_oe, .o_aux_clock_pin_in,
    .o_low_freq_osc_trim, .o_pll_feedback_divider, .o_pll_power_down);
  // ====
  // tasks
  task automatic chk(input string s, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge i_sys_clk);
    i_wr <= 1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 0;
    repeat (2) @(negedge i_sys_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_sys_clk);
    i_rd <= 1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 0;
    @(negedge i_sys_clk);
    v = o_rdata;
  endtask
  function automatic logic [7:0] fb_exp(input logic [1:0] c);
    return (c == 2'h1) ? 8'h1B : (c == 2'h2) ? 8'h1C : 8'h17;
  endfunction
  // rising edges of the pin over 512 cycles, one either way allowed
  task automatic edges(input logic [7:0] c, input int e);
    wr(8'h3D, c);
    repeat (16) @(negedge i_sys_clk);
    n = 0;
    repeat (512)
    begin
      p = o_aux_clock_pin;
      @(negedge i_sys_clk);
      n += int'(!p && o_aux_clock_pin);
    end
    chk("edges", 8'(n >= e - 1 && n <= e + 1), 8'h01);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge i_sys_clk);
    mismatches++;
    test_done;
  end
  // ====
  // main sequence
  initial
  begin
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 0;
    @(negedge i_sys_clk);
    chk("trim", o_low_freq_osc_trim, 8'h80);
    rd(8'h3E);
    chk("div", v, 8'h08);
    for (int i = 0; i < 16; i++)
    begin
      r = 8'($random(seed));
      wr(8'h3C, r);
      chk("trim", o_low_freq_osc_trim, r);
      r = 8'h08 + 8'($random(seed)) % 8'hF7;
      wr(8'h3E, r);
      rd(8'h3E);
      chk("div", v, r);
    end
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h3D, 8'(i));
      rd(8'h3D);
      chk("ctrl", v, 8'(i));
      chk("fb", 8'(o_pll_feedback_divider), fb_exp(2'(i)));
      chk("pd", 8'(o_pll_power_down), 8'(i[2]));
    end
    wr(8'h50, 8'hFF);
    rd(8'h50);
    chk("unmapped", v, 8'h00);
    for (int i = 16; i < 256; i += 8)
    begin
      wr(8'h3D, 8'(i));
      chk("oe", 8'(o_aux_clock_pin_oe), 8'(i[3] && i < 192));
      if (i[7:5] == 3'b001 && i[3])
        chk("level", 8'(o_aux_clock_pin), 8'(i[4]));
    end
    wr(8'h3D, 8'h00);
    @(posedge i_sys_clk);
    i_gpio_oe <= 1;
    i_gpio_out <= 1'($random(seed));
    repeat (4) @(negedge i_sys_clk);
    p = i_gpio_out;
    chk("gpio", {o_aux_clock_pin_oe, o_aux_clock_pin}, {1'b1, p});
    // pin level comes back through two sync stages and one register
    repeat (8)
    begin
      @(negedge i_sys_clk);
      r = ph - 8'h03;
      chk("pin in", 8'(o_aux_clock_pin_in), 8'(r[3] ^ r[0]));
    end
    for (int t = 0; t < 4; t++)
    begin
      wr(8'h3D, 8'(8'h88 + 16 * t));
      p = o_aux_clock_pin;
      @(posedge i_sys_clk);
      i_timer_ovf <= 4'(1 << t);
      @(posedge i_sys_clk);
      i_timer_ovf <= 4'(1 << ((t + 1) % 4));
      @(posedge i_sys_clk);
      i_timer_ovf <= 4'h0;
      repeat (3) @(negedge i_sys_clk);
      chk("toggle", 8'(o_aux_clock_pin), 8'(!p));
    end
    for (int s = 4; s < 8; s++)
      edges(8'(16 * s + 8), 128 >> (s - 4));
    wr(8'h3E, 8'h08);
    edges(8'h18, 16);
    wr(8'h3E, 8'h20);
    edges(8'h18, 4);
    edges(8'h1C, 0);
    rd(8'h3F);
    chk("run", v & 8'hF8, 8'h00);
    wr(8'h3E, 8'h05);
    edges(8'h18, 0);
    rd(8'h3F);
    chk("run", v & 8'hF8, 8'h00);
    wr(8'h3E, 8'h0B);
    rd(8'h3F);
    chk("run", v & 8'hF8, 8'h08);
    test_done;
  end
endmodule
`default_nettype wire
